// File: usc_defs.svh
// Purpose: Offsets, field positions and reset values of the USB control block
// Assumes: 8-bit register port
// Notes: Definitions only
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH
`define USC_OFF_CLKSEL   8'h22
`define USC_OFF_ADDR     8'h23
`define USC_OFF_HALT     8'h24
`define USC_OFF_STATUS   8'h25
`define USC_OFF_REQ      8'h21
`define USC_BIT_CLKEN    3
`define USC_BIT_DEEP_SUSPEND_POWER_CUT    4
`define USC_BIT_PLLSEL   5
`define USC_BIT_XTAL6    6
`define USC_BIT_AUTO_ADDRESS_UPDATE     0
`define USC_BIT_ERR      1
`define USC_BIT_OUT      2
`define USC_BIT_IN       3
`define USC_BIT_NAK      4
`define USC_BIT_CRC      5
`define USC_BIT_TOKN     6
`define USC_BIT_NMASK    7
`define USC_RST_BYTE     8'h00
`define USC_RST_ADDR     7'h00
`define USC_EP_LAST      3'h5
`define USC_EP_MASK      8'h3f
`endif

// File: usc_pkg.sv
// Purpose: Types of the USB control block
// Assumes: Used with usc_defs.svh
// Notes: Holds the state record type
package usc_pkg;
	typedef struct packed {
		logic [7:0] clksel;
		logic [7:0] addr;
		logic [6:0] live_addr;
		logic       addr_pend;
		logic [5:0] halt;
		logic [7:0] status;
		logic [5:0] req;
		logic [7:0] rdata;
		logic       irq;
		logic [5:0] ep_sel;
		logic       stall_hs;
	} usc_state_type;
endpackage : usc_pkg

// File: usc_ctrl.sv
// Purpose: Clock, address, halt and token status logic of a USB engine
// Assumes: Engine events are one-cycle pulses synchronous to clk
// Notes: Firmware clears lose to same-cycle hardware sets
`timescale 1ns/100ps
`default_nettype none
`include "usc_defs.svh"

module usc_ctrl
	import usc_pkg::*;
(
	input  wire logic       clk,          // System clock 25 MHz
	input  wire logic       nrst,         // Sync reset, active low
	input  wire logic [7:0] addr,         // Register address
	input  wire logic [7:0] wdata,        // Write data
	input  wire logic       wr,           // Write strobe
	input  wire logic       rd,           // Read strobe
	output logic      [7:0] rdata,        // Read data, cycle after rd
	input  wire logic       usb_reset,    // Bus reset pulse
	input  wire logic       setup_tok,    // Valid setup token pulse
	input  wire logic       in_tok,       // Current token is IN, level
	input  wire logic       tok_active,   // Token packet in progress
	input  wire logic       out_data,     // OUT with data received pulse
	input  wire logic       ep0_err,      // Endpoint 0 FIFO error pulse
	input  wire logic       pkt_err,      // CRC/PID/token error pulse
	input  wire logic       nak_sent,     // NAK handshake sent pulse
	input  wire logic       in_acked,     // Host read IN data pulse
	input  wire logic [2:0] tok_ep,       // Endpoint of current token
	input  wire logic       ep_access,    // Endpoint accessed pulse
	output logic      [5:0] endpoint_fifo_select, // One-hot FIFO select, all zero for selector codes 6-7
	output logic            usb_clock_enable,     // USB clock gate
	output logic            deep_suspend_power_cut, // Deep suspend power cut
	output logic            pll_clock_select,     // 1 PLL, 0 oscillator
	output logic            crystal_freq_select,  // 1 for 6 MHz crystal
	output logic            remote_wakeup_enable, // Wake-up enable
	output logic      [6:0] device_address_field, // Address in use
	output logic            stall_handshake,      // Answer STALL
	output logic            usb_irq               // USB interrupt
);
	usc_state_type s_q;
	usc_state_type s_d;
	logic          wr_clk;
	logic          wr_adr;
	logic          wr_hlt;
	logic          wr_sts;
	logic          wr_req;
	logic [7:0]    rd_mux;

	// Write decode
	assign wr_clk = wr && (addr == `USC_OFF_CLKSEL);
	assign wr_adr = wr && (addr == `USC_OFF_ADDR);
	assign wr_hlt = wr && (addr == `USC_OFF_HALT);
	assign wr_sts = wr && (addr == `USC_OFF_STATUS);
	assign wr_req = wr && (addr == `USC_OFF_REQ);

	// Read mux, unmapped reads zero
	always_comb begin
		rd_mux = `USC_RST_BYTE;
		unique case (addr)
			`USC_OFF_CLKSEL: rd_mux = {1'b0, s_q.clksel[6:0]};
			`USC_OFF_ADDR:   rd_mux = s_q.addr;
			`USC_OFF_HALT:   rd_mux = {2'b00, s_q.halt};
			`USC_OFF_STATUS: rd_mux = s_q.status;
			`USC_OFF_REQ:    rd_mux = {2'b00, s_q.req};
			default:         rd_mux = `USC_RST_BYTE;
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.rdata = rd ? rd_mux : `USC_RST_BYTE;
		if (wr_clk) begin
			s_d.clksel = {1'b0, wdata[6:0]};
		end
		// Address write, immediate or deferred
		if (wr_adr) begin
			s_d.addr = wdata;
			if (s_q.status[`USC_BIT_AUTO_ADDRESS_UPDATE]) begin
				s_d.addr_pend = 1'b1;
			end else begin
				s_d.live_addr = wdata[7:1];
				s_d.addr_pend = 1'b0;
			end
		end else if (s_q.addr_pend && in_acked) begin
			s_d.live_addr = s_q.addr[7:1];
			s_d.addr_pend = 1'b0;
		end
		// Halt bits
		if (wr_hlt) begin
			s_d.halt = wdata[5:0];
		end
		if (setup_tok) begin
			s_d.halt = 6'h00;
		end
		// Status firmware writes for writable bits
		if (wr_sts) begin
			s_d.status[`USC_BIT_AUTO_ADDRESS_UPDATE]  = wdata[`USC_BIT_AUTO_ADDRESS_UPDATE];
			s_d.status[`USC_BIT_ERR]   = wdata[`USC_BIT_ERR];
			s_d.status[`USC_BIT_OUT]   = wdata[`USC_BIT_OUT];
			s_d.status[`USC_BIT_CRC]   = wdata[`USC_BIT_CRC];
			s_d.status[`USC_BIT_NMASK] = wdata[`USC_BIT_NMASK];
		end
		if (setup_tok) begin
			s_d.status[`USC_BIT_OUT] = 1'b0;
		end
		// Hardware sets win over clears
		if (ep0_err) begin
			s_d.status[`USC_BIT_ERR] = 1'b1;
		end
		if (out_data) begin
			s_d.status[`USC_BIT_OUT] = 1'b1;
		end
		if (pkt_err) begin
			s_d.status[`USC_BIT_CRC] = 1'b1;
		end
		s_d.status[`USC_BIT_IN]   = in_tok;
		s_d.status[`USC_BIT_TOKN] = ~tok_active;
		if (nak_sent) begin
			s_d.status[`USC_BIT_NAK] = 1'b1;
		end else if (tok_active && s_q.status[`USC_BIT_TOKN]) begin
			// Only the first cycle of a new token clears the NAK flag
			s_d.status[`USC_BIT_NAK] = 1'b0;
		end
		// Request flags
		if (wr_req) begin
			s_d.req = s_q.req & wdata[5:0];
		end
		if (ep_access && tok_ep <= `USC_EP_LAST) begin
			s_d.req[tok_ep] = 1'b1;
		end
		// Interrupt: requests or unmasked NAK
		s_d.irq = (|s_d.req) ||
			(nak_sent && !s_q.status[`USC_BIT_NMASK]);
		// Endpoint select decode
		s_d.ep_sel = 6'h00;
		if (s_d.clksel[2:0] <= `USC_EP_LAST) begin
			s_d.ep_sel[s_d.clksel[2:0]] = 1'b1;
		end
		s_d.stall_hs = (tok_ep <= `USC_EP_LAST) &&
			s_d.halt[tok_ep] && tok_active;
		// Bus reset clears the block
		if (usb_reset) begin
			s_d = '0;
			s_d.status[`USC_BIT_TOKN] = 1'b1;
			s_d.ep_sel = 6'h01;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.status[`USC_BIT_TOKN] <= 1'b1;
			s_q.ep_sel <= 6'h01;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign rdata                  = s_q.rdata;
	assign endpoint_fifo_select   = s_q.ep_sel;
	assign usb_clock_enable       = s_q.clksel[`USC_BIT_CLKEN];
	assign deep_suspend_power_cut = s_q.clksel[`USC_BIT_DEEP_SUSPEND_POWER_CUT];
	assign pll_clock_select       = s_q.clksel[`USC_BIT_PLLSEL];
	assign crystal_freq_select    = s_q.clksel[`USC_BIT_XTAL6];
	assign remote_wakeup_enable   = s_q.addr[0];
	assign device_address_field   = s_q.live_addr;
	assign stall_handshake        = s_q.stall_hs;
	assign usb_irq                = s_q.irq;

	// Steps of a deferred address update
	sequence s_pend_ack;
		s_q.addr_pend && in_acked && !wr_adr && !usb_reset;
	endsequence
	sequence s_pend_wait;
		s_q.addr_pend && !in_acked && !wr_adr && !usb_reset;
	endsequence

	// Endpoint selection
	a_sel_onehot: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.clksel[2:0] <= `USC_EP_LAST) |-> $onehot(endpoint_fifo_select))
		else $error("valid selector not one-hot");
	// Bus reset selects endpoint 0
	a_sel_bus_reset: assert property (@(posedge clk) disable iff (!nrst)
		usb_reset |=> endpoint_fifo_select == 6'h01)
		else $error("bus reset left wrong selection");
	// Reserved selector codes
	a_sel_reserved: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.clksel[2:1] == 2'b11) |-> endpoint_fifo_select == 6'h00)
		else $error("reserved selector selected a fifo");

	// Clock control bits follow writes
	a_clk_enable_bit: assert property (@(posedge clk) disable iff (!nrst)
		(wr_clk && !usb_reset)
		|=> usb_clock_enable == $past(wdata[`USC_BIT_CLKEN]))
		else $error("usb clock enable not written");
	// Suspend power cut bit
	a_suspend_bit: assert property (@(posedge clk) disable iff (!nrst)
		(wr_clk && !usb_reset)
		|=> deep_suspend_power_cut == $past(wdata[`USC_BIT_DEEP_SUSPEND_POWER_CUT]))
		else $error("suspend bit not written");
	// Clock source bit
	a_pll_bit: assert property (@(posedge clk) disable iff (!nrst)
		(wr_clk && !usb_reset)
		|=> pll_clock_select == $past(wdata[`USC_BIT_PLLSEL]))
		else $error("clock source bit not written");
	// Crystal frequency bit
	a_xtal_bit: assert property (@(posedge clk) disable iff (!nrst)
		(wr_clk && !usb_reset)
		|=> crystal_freq_select == $past(wdata[`USC_BIT_XTAL6]))
		else $error("crystal bit not written");

	// Unimplemented bits
	a_clk_bit7: assert property (@(posedge clk) disable iff (!nrst)
		$past(rd && addr == `USC_OFF_CLKSEL) |-> !rdata[7])
		else $error("clock register bit 7 not zero");
	a_clk_msb_store: assert property (@(posedge clk) disable iff (!nrst)
		!s_q.clksel[7])
		else $error("clock register bit 7 stored");
	a_halt_top_bits: assert property (@(posedge clk) disable iff (!nrst)
		$past(rd && addr == `USC_OFF_HALT) |-> rdata[7:6] == 2'b00)
		else $error("halt register bits 7-6 not zero");
	// Read data only in the cycle after a read
	a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
		!rd |=> rdata == 8'h00)
		else $error("read data without a read");

	// Address register reset
	a_addr_reset: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> (s_q.addr == 8'h00 && device_address_field == 7'h00))
		else $error("address register not zero after reset");
	a_addr_bus_reset: assert property (@(posedge clk) disable iff (!nrst)
		usb_reset |=> (s_q.addr == 8'h00 && device_address_field == 7'h00))
		else $error("bus reset left an address");
	// Address register layout
	a_addr_store: assert property (@(posedge clk) disable iff (!nrst)
		(wr_adr && !usb_reset) |=> s_q.addr == $past(wdata))
		else $error("address register not written");
	a_wake_bit: assert property (@(posedge clk) disable iff (!nrst)
		(wr_adr && !usb_reset) |=> remote_wakeup_enable == $past(wdata[0]))
		else $error("wake-up bit not written");

	// Halt bits
	a_setup_clears_halt: assert property (@(posedge clk) disable iff (!nrst)
		setup_tok |=> s_q.halt == 6'h00)
		else $error("halt bits not cleared by setup");
	a_halt_bus_reset: assert property (@(posedge clk) disable iff (!nrst)
		usb_reset |=> s_q.halt == 6'h00)
		else $error("halt bits not cleared by bus reset");
	a_halt_write: assert property (@(posedge clk) disable iff (!nrst)
		(wr_hlt && !setup_tok && !usb_reset)
		|=> s_q.halt == $past(wdata[5:0]))
		else $error("halt bits not written");

	// Immediate and deferred address adoption
	a_immediate_addr: assert property (@(posedge clk) disable iff (!nrst)
		(wr_adr && !s_q.status[`USC_BIT_AUTO_ADDRESS_UPDATE] && !usb_reset)
		|=> device_address_field == $past(wdata[7:1]))
		else $error("address not adopted at once");
	a_deferred_addr: assert property (@(posedge clk) disable iff (!nrst)
		(wr_adr && s_q.status[`USC_BIT_AUTO_ADDRESS_UPDATE] && !usb_reset)
		|=> device_address_field == $past(s_q.live_addr))
		else $error("deferred address taken early");
	a_addr_pend_set: assert property (@(posedge clk) disable iff (!nrst)
		(wr_adr && s_q.status[`USC_BIT_AUTO_ADDRESS_UPDATE] && !usb_reset)
		|=> s_q.addr_pend)
		else $error("deferred address not armed");
	a_addr_wait: assert property (@(posedge clk) disable iff (!nrst)
		s_pend_wait |=> $stable(device_address_field))
		else $error("address changed before IN ack");
	a_addr_adopt: assert property (@(posedge clk) disable iff (!nrst)
		s_pend_ack |=> device_address_field == $past(s_q.addr[7:1]))
		else $error("stored address not adopted");

	// Error and OUT flags set by hardware and held until cleared
	a_err_sticky: assert property (@(posedge clk) disable iff (!nrst)
		(ep0_err && !usb_reset) |=> s_q.status[`USC_BIT_ERR])
		else $error("error flag not set");
	a_err_held: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.status[`USC_BIT_ERR] && !wr_sts && !usb_reset)
		|=> s_q.status[`USC_BIT_ERR])
		else $error("error flag lost");
	a_out_flag: assert property (@(posedge clk) disable iff (!nrst)
		(out_data && !usb_reset) |=> s_q.status[`USC_BIT_OUT])
		else $error("out flag not set");
	a_out_setup_clear: assert property (@(posedge clk) disable iff (!nrst)
		(setup_tok && !out_data && !usb_reset) |=> !s_q.status[`USC_BIT_OUT])
		else $error("out flag not cleared by setup");
	a_crc_flag: assert property (@(posedge clk) disable iff (!nrst)
		(pkt_err && !usb_reset) |=> s_q.status[`USC_BIT_CRC])
		else $error("packet error flag not set");
	a_crc_held: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.status[`USC_BIT_CRC] && !wr_sts && !usb_reset)
		|=> s_q.status[`USC_BIT_CRC])
		else $error("packet error flag lost");

	// Token status bits
	a_in_follows: assert property (@(posedge clk) disable iff (!nrst)
		!usb_reset |=> s_q.status[`USC_BIT_IN] == $past(in_tok))
		else $error("IN status does not follow token");
	a_nak_set: assert property (@(posedge clk) disable iff (!nrst)
		(nak_sent && !usb_reset) |=> s_q.status[`USC_BIT_NAK])
		else $error("NAK status not set");
	a_nak_token_clear: assert property (@(posedge clk) disable iff (!nrst)
		(tok_active && s_q.status[`USC_BIT_TOKN] && !nak_sent && !usb_reset)
		|=> !s_q.status[`USC_BIT_NAK])
		else $error("NAK status not cleared by new token");
	a_token_low: assert property (@(posedge clk) disable iff (!nrst)
		(tok_active && !usb_reset) |=> !s_q.status[`USC_BIT_TOKN])
		else $error("token flag not low");
	a_token_idle: assert property (@(posedge clk) disable iff (!nrst)
		!tok_active |=> s_q.status[`USC_BIT_TOKN])
		else $error("token flag low while idle");

	// Interrupt sources
	a_nak_mask_irq: assert property (@(posedge clk) disable iff (!nrst)
		(nak_sent && !s_q.status[`USC_BIT_NMASK] && !usb_reset)
		|=> usb_irq)
		else $error("unmasked nak raised no interrupt");
	a_nak_masked: assert property (@(posedge clk) disable iff (!nrst)
		(nak_sent && s_q.status[`USC_BIT_NMASK] && s_q.req == 6'h00 &&
		!ep_access) |=> !usb_irq)
		else $error("masked nak raised an interrupt");
	a_req_set: assert property (@(posedge clk) disable iff (!nrst)
		(ep_access && tok_ep <= `USC_EP_LAST && !usb_reset)
		|=> s_q.req[$past(tok_ep)])
		else $error("request flag not set");
	a_req_irq: assert property (@(posedge clk) disable iff (!nrst)
		(ep_access && tok_ep <= `USC_EP_LAST && !usb_reset) |=> usb_irq)
		else $error("endpoint access raised no interrupt");

	// Stall handshake
	a_stall_token: assert property (@(posedge clk) disable iff (!nrst)
		(tok_active && tok_ep <= `USC_EP_LAST && s_q.halt[tok_ep] &&
		!setup_tok && !wr_hlt && !usb_reset) |=> stall_handshake)
		else $error("halted endpoint not stalled");
	a_stall_idle: assert property (@(posedge clk) disable iff (!nrst)
		!tok_active |=> !stall_handshake)
		else $error("stall outside a token");
endmodule : usc_ctrl
`default_nettype wire

// File: usc_host_model.sv
// Purpose: Host-side event source for the USB control block
// Assumes: Events are one-cycle pulses launched after a clk rise
// Notes: ev bits: 0 reset 1 setup 2 out 3 err 4 pkt 5 nak 6 ack 7 access
`timescale 1ns/100ps
`default_nettype none
module usc_host_model (
	input  wire logic       clk,        // System clock
	output logic      [7:0] ev,         // Event pulses
	output logic            in_tok,     // IN token level
	output logic            tok_active, // Token in progress
	output logic      [2:0] tok_ep      // Token endpoint
);
	// Idle bus at time zero
	initial begin
		ev = 8'h00;
		in_tok = 1'b0;
		tok_active = 1'b0;
		tok_ep = 3'h0;
	end
	// One-cycle event pulse aimed at one endpoint
	task automatic fire(input logic [7:0] e, input logic [2:0] ep);
		@(posedge clk);
		ev <= e;
		tok_ep <= ep;
		@(posedge clk);
		ev <= 8'h00;
	endtask : fire
	// Token frame opens and stays until closed
	task automatic tok_on(input logic is_in, input logic [2:0] ep);
		@(posedge clk);
		tok_active <= 1'b1;
		in_tok <= is_in;
		tok_ep <= ep;
	endtask : tok_on
	// Token frame ends, IN level drops with it
	task automatic tok_off();
		@(posedge clk);
		tok_active <= 1'b0;
		in_tok <= 1'b0;
	endtask : tok_off
endmodule : usc_host_model
`default_nettype wire

// File: test_usb_sie_control_status.sv
// Purpose: Self-checking bench of the USB control block
// Assumes: Register port reads answer one cycle after rd
// Notes: Host events come from usc_host_model
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("wrong value %s exp %h got %h", w, e, g); end end
module test_usb_sie_control_status;
	logic clk, nrst, wr, rd, usb_clock_enable, deep_suspend_power_cut;
	logic pll_clock_select, crystal_freq_select, remote_wakeup_enable;
	logic stall_handshake, usb_irq, in_tok, tok_active;
	logic [7:0] addr, wdata, rdata, ev, d;
	logic [6:0] device_address_field;
	logic [5:0] endpoint_fifo_select;
	logic [2:0] tok_ep;
	int n_errors = 0;
	int check_count = 0;
	usc_host_model host (.clk, .ev, .in_tok, .tok_active, .tok_ep);
	usc_ctrl dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
		.usb_reset(ev[0]), .setup_tok(ev[1]), .in_tok, .tok_active,
		.out_data(ev[2]), .ep0_err(ev[3]), .pkt_err(ev[4]),
		.nak_sent(ev[5]), .in_acked(ev[6]), .tok_ep, .ep_access(ev[7]),
		.endpoint_fifo_select, .usb_clock_enable, .deep_suspend_power_cut,
		.pll_clock_select, .crystal_freq_select, .remote_wakeup_enable,
		.device_address_field, .stall_handshake, .usb_irq);
	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// One-cycle register write
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	// Read and compare in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK("rdata", e, rdata)
	endtask : rchk
	// Counts and verdict
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Hang guard, tests need well under 2000 cycles
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	// Main sequence
	initial begin
		{wr, rd, addr, wdata} = 18'h0_0000;
		nrst = 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rchk(8'h22, 8'h00); rchk(8'h23, 8'h00);
		rchk(8'h24, 8'h00); rchk(8'h30, 8'h00);
		rchk(8'h25, 8'h40);
		`CHK("select", 6'h01, endpoint_fifo_select)
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			wreg(8'h22, 8'(i));
			#1 `CHK("select", (i < 6) ? 6'(1 << i) : 6'h00, endpoint_fifo_select)
		end
		`CHK("clk bits", 4'h0, {crystal_freq_select, pll_clock_select, deep_suspend_power_cut, usb_clock_enable})
		wreg(8'h22, 8'hfd);
		rchk(8'h22, 8'h7d);
		`CHK("clk bits", 4'hf, {crystal_freq_select, pll_clock_select, deep_suspend_power_cut, usb_clock_enable})
		$display("clock select done");
		wreg(8'h23, 8'h0b);
		#1 `CHK("addr", 7'h05, device_address_field)
		`CHK("wake", 1'b1, remote_wakeup_enable)
		wreg(8'h25, 8'h01);
		wreg(8'h23, 8'h14);
		#1 `CHK("addr held", 7'h05, device_address_field)
		host.fire(8'h40, 3'h0);
		@(posedge clk);
		#1 `CHK("addr late", 7'h0a, device_address_field)
		rchk(8'h23, 8'h14);
		host.fire(8'h02, 3'h0);
		wreg(8'h25, 8'h00);
		$display("address done");
		wreg(8'h24, 8'hff);
		rchk(8'h24, 8'h3f);
		host.tok_on(1'b1, 3'h2);
		rchk(8'h25, 8'h08);
		`CHK("stall", 1'b1, stall_handshake)
		host.tok_off();
		host.fire(8'h02, 3'h0);
		rchk(8'h24, 8'h00);
		$display("halt done");
		host.fire(8'h1c, 3'h0);
		rchk(8'h25, 8'h66);
		host.fire(8'h02, 3'h0);
		rchk(8'h25, 8'h62);
		wreg(8'h25, 8'h00);
		rchk(8'h25, 8'h40);
		host.fire(8'h20, 3'h0);
		#1 `CHK("nak irq", 1'b1, usb_irq)
		rchk(8'h25, 8'h50);
		wreg(8'h25, 8'h80);
		host.fire(8'h20, 3'h0);
		#1 `CHK("masked", 1'b0, usb_irq)
		$display("status done");
		host.fire(8'h80, 3'h3);
		#1 `CHK("req irq", 1'b1, usb_irq)
		rchk(8'h21, 8'h08);
		wreg(8'h21, 8'h00);
		rchk(8'h21, 8'h00);
		`CHK("irq off", 1'b0, usb_irq)
		wreg(8'h22, 8'hff);
		host.fire(8'h01, 3'h0);
		rchk(8'h22, 8'h00);
		$display("request and bus reset done");
		test_done();
	end
endmodule : test_usb_sie_control_status
`default_nettype wire
